// ===== hdl/pmc_regs.v
// How it works
// R1: bit 23 set blocks task priority reports
// R2: bit 24 selects shared or adaptive mode
// R3: adaptive mode shares L1 on equal bases
// R4: mode only acts with multiple logical processors
// R5: software leaves bit 24 without context capability
// R6: bit 34 set disables and hides execute-disable
// R7: bit 34 clear keeps execute-disable available
// R8: software leaves bit 34 when feature absent
// R9: writing 1 without capability raises fault
// R10: platform register reports requirement in bit 18
// R11: source register holds last branch before exception
// R12: reserved bits read zero, ignore writes
// R13: extended 64-bit mode keeps full address
`timescale 1ns/1ps
`include "pmc_regs_map.vh"

module pmc_regs #(
   parameter       TPR_DIS_RESET = 1'b0,
   parameter       HAS_SMT       = 1'b1,
   parameter       HAS_CTX_ID    = 1'b1,
   parameter       HAS_XD        = 1'b1,
   parameter       PLAT_REQ      = 1'b0
) (
   // clock and reset
   input  wire        aclk,
   input  wire        aresetn,
   // axi4-lite slave
   input  wire [13:0] s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [13:0] s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // core status inputs
   input  wire        branch_retire,
   input  wire [63:0] branch_addr,
   input  wire        exception_taken,
   input  wire        extended_64bit_mode,
   input  wire [63:0] page_table_base_lp0,
   input  wire [63:0] page_table_base_lp1,
   // control outputs
   output reg         task_priority_report_en,
   output reg         l1_share_en,
   output reg         execute_disable_protection_en,
   output reg         ext_id_xd_flag,
   output reg         general_protection_fault
);

   reg         tpr_dis_q;
   reg         l1_shared_q;
   reg         xd_dis_q;
   reg  [63:0] last_branch_q;
   reg  [63:0] ler_from_q;
   reg  [13:0] awaddr_q;
   reg         aw_full_q;
   reg  [31:0] wdata_q;
   reg  [3:0]  wstrb_q;
   reg         w_full_q;

   wire        do_write = aw_full_q && w_full_q && !s_axi_bvalid;
   wire [13:0] misc_lo  = {`PMC_IDX_MISC_ENABLE, 2'b00};
   wire [13:0] misc_hi  = misc_lo + `PMC_HI_OFS;
   wire [13:0] plat_lo  = {`PMC_IDX_PLATFORM, 2'b00};
   wire [13:0] plat_hi  = plat_lo + `PMC_HI_OFS;
   wire [13:0] ler_lo   = {`PMC_IDX_LER_FROM, 2'b00};
   wire [13:0] ler_hi   = ler_lo + `PMC_HI_OFS;

   assign s_axi_awready = !aw_full_q;
   assign s_axi_wready  = !w_full_q;
   assign s_axi_arready = !s_axi_rvalid;

   ////////////////////////////////////////////////////////////////
   // write path: address and data captured in either order
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_q <= 1'b0;
         w_full_q  <= 1'b0;
         awaddr_q  <= 14'h0000;
         wdata_q   <= 32'h00000000;
         wstrb_q   <= 4'h0;
      end else begin
         if (s_axi_awvalid && !aw_full_q) begin
            aw_full_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
         end else if (do_write) begin
            aw_full_q <= 1'b0;
         end
         if (s_axi_wvalid && !w_full_q) begin
            w_full_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
         end else if (do_write) begin
            w_full_q <= 1'b0;
         end
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         tpr_dis_q                <= TPR_DIS_RESET;                    // [R1]
         l1_shared_q              <= `PMC_RST_L1_SHARED;               // [R2]
         xd_dis_q                 <= `PMC_RST_XD_DIS;                  // [R7]
         s_axi_bvalid             <= 1'b0;
         s_axi_bresp              <= `PMC_RESP_OKAY;
         general_protection_fault <= 1'b0;
      end else begin
         general_protection_fault <= 1'b0;
         if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= `PMC_RESP_OKAY;
            if (awaddr_q[13:2] == misc_lo[13:2]) begin
               if (wstrb_q[2])
                  tpr_dis_q <= wdata_q[`PMC_BIT_TPR_DIS];              // [R1]
               // mode bit is only writable on multithreaded parts with context capability
               if (wstrb_q[3] && HAS_SMT && HAS_CTX_ID)
                  l1_shared_q <= wdata_q[`PMC_BIT_L1_SHARED];          // [R4] [R5]
            end else if (awaddr_q[13:2] == misc_hi[13:2]) begin
               if (wstrb_q[0]) begin
                  if (!HAS_XD && wdata_q[`PMC_BIT_XD_DIS - 32]) begin
                     general_protection_fault <= 1'b1;                  // [R9]
                     s_axi_bresp              <= `PMC_RESP_SLVERR;      // [R9]
                  end else if (HAS_XD) begin
                     xd_dis_q <= wdata_q[`PMC_BIT_XD_DIS - 32];        // [R6] [R8]
                  end
               end
            end else if (awaddr_q[13:2] == plat_lo[13:2] || awaddr_q[13:2] == plat_hi[13:2] ||
                         awaddr_q[13:2] == ler_lo[13:2] || awaddr_q[13:2] == ler_hi[13:2]) begin
               s_axi_bresp <= `PMC_RESP_OKAY;                           // [R12]
            end else begin
               s_axi_bresp <= `PMC_RESP_SLVERR;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // last exception record: latch tracked branch when exception occurs
   always @(posedge aclk) begin
      if (!aresetn) begin
         last_branch_q <= 64'h0000000000000000;
         ler_from_q    <= 64'h0000000000000000;
      end else begin
         if (branch_retire)
            last_branch_q <= extended_64bit_mode ? branch_addr :
                             {32'h00000000, branch_addr[31:0]};        // [R13]
         // a branch in the same cycle as the exception is after it, so not recorded
         if (exception_taken)
            ler_from_q <= last_branch_q;                                // [R11]
      end
   end

   ////////////////////////////////////////////////////////////////
   // control outputs
   always @(posedge aclk) begin
      if (!aresetn) begin
         task_priority_report_en       <= 1'b0;
         l1_share_en                   <= 1'b0;
         execute_disable_protection_en <= 1'b0;
         ext_id_xd_flag                <= 1'b0;
      end else begin
         task_priority_report_en       <= !tpr_dis_q;                   // [R1]
         l1_share_en                   <= HAS_SMT && (l1_shared_q ||
                                          page_table_base_lp0 == page_table_base_lp1); // [R3] [R4]
         execute_disable_protection_en <= HAS_XD && !xd_dis_q;          // [R6] [R7]
         ext_id_xd_flag                <= HAS_XD && !xd_dis_q;          // [R6]
      end
   end

   ////////////////////////////////////////////////////////////////
   // read path, one cycle after address accepted
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= `PMC_RESP_OKAY;
      end else if (s_axi_rvalid) begin
         if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end else if (s_axi_arvalid) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= `PMC_RESP_OKAY;
         s_axi_rdata  <= 32'h00000000;                                  // [R12]
         if (s_axi_araddr[13:2] == misc_lo[13:2]) begin
            s_axi_rdata[`PMC_BIT_TPR_DIS]   <= tpr_dis_q;
            s_axi_rdata[`PMC_BIT_L1_SHARED] <= l1_shared_q;
         end else if (s_axi_araddr[13:2] == misc_hi[13:2]) begin
            s_axi_rdata[`PMC_BIT_XD_DIS - 32] <= xd_dis_q;
         end else if (s_axi_araddr[13:2] == plat_lo[13:2]) begin
            s_axi_rdata[`PMC_BIT_PLAT_REQ] <= PLAT_REQ;                // [R10]
         end else if (s_axi_araddr[13:2] == plat_hi[13:2]) begin
            s_axi_rdata <= 32'h00000000;
         end else if (s_axi_araddr[13:2] == ler_lo[13:2]) begin
            s_axi_rdata <= ler_from_q[31:0];                            // [R11]
         end else if (s_axi_araddr[13:2] == ler_hi[13:2]) begin
            s_axi_rdata <= ler_from_q[63:32];                           // [R13]
         end else begin
            s_axi_rresp <= `PMC_RESP_SLVERR;
         end
      end
   end

endmodule // pmc_regs

// ===== inc/pmc_regs_map.vh
`ifndef PMC_REGS_MAP_VH
`define PMC_REGS_MAP_VH

// printed register numbers are not all multiples of four: each is an index, byte address = 4 * index
`define PMC_IDX_PLATFORM      12'h1A1
`define PMC_IDX_LER_FROM      12'h1D7
`define PMC_IDX_MISC_ENABLE   12'h1A0
`define PMC_ADDR_W            14

// 64-bit registers are split into low and high words; high word sits at byte address + 0x2000 of a second index slot
`define PMC_HI_OFS            14'h2000

// bit positions within the 64-bit enable register and, for bit 18, the platform register
`define PMC_BIT_TPR_DIS       23
`define PMC_BIT_L1_SHARED     24
`define PMC_BIT_XD_DIS        34
`define PMC_BIT_PLAT_REQ      18

// reset values
`define PMC_RST_L1_SHARED     1'b0
`define PMC_RST_XD_DIS        1'b0

// responses
`define PMC_RESP_OKAY         2'b00
`define PMC_RESP_SLVERR       2'b10

`endif

// ===== verification/pmc_regs_asserts.sv
`timescale 1ns/1ps
module pmc_regs_asserts #(
   parameter HAS_XD  = 1'b1,
   parameter HAS_SMT = 1'b1
) (
   // clock, reset and bus handshakes
   input wire logic        aclk, aresetn, s_axi_wvalid, s_axi_bvalid, s_axi_bready,
   input wire logic        s_axi_arready, s_axi_rvalid, s_axi_rready,
   // control outputs and their causes
   input wire logic        task_priority_report_en, l1_share_en, execute_disable_protection_en,
   input wire logic        ext_id_xd_flag, general_protection_fault,
   input wire logic [63:0] page_table_base_lp0, page_table_base_lp1
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   ////////////////////////////////////////////////////////////////////////////////
   a_xd_flag_match: assert property (ext_id_xd_flag == execute_disable_protection_en)
      else $error("identification flag differs from protection enable");
   a_no_fault_xd: assert property (HAS_XD |-> !general_protection_fault)
      else $error("fault raised although protection exists");
   a_l1_share_eq: assert property (HAS_SMT && page_table_base_lp0 == page_table_base_lp1 |=> l1_share_en)
      else $error("equal bases but cache not shared");
   // a write lands a few edges after wvalid falls, so four quiet cycles are needed
   a_cfg_stable: assert property (((!s_axi_wvalid)[*4] ##0 $past(aresetn, 4)) |->
      $stable(task_priority_report_en) && $stable(execute_disable_protection_en))
      else $error("control changed without a write");
   a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
      else $error("read answer dropped before taken");
   a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write answer dropped before taken");
   a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while answer pending");
   a_b_after_w: assert property ($rose(s_axi_bvalid) |-> $past(s_axi_wvalid, 2))
      else $error("write answer without data two cycles before");
   c_read: cover property (s_axi_rvalid && s_axi_rready);
   c_write: cover property (s_axi_bvalid && s_axi_bready);
   c_xd_off: cover property ($fell(execute_disable_protection_en));
endmodule // pmc_regs_asserts

// ===== verification/tb_pmc_regs.sv
`timescale 1ns/1ps
module tb_pmc_regs;
   logic        aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic        s_axi_arvalid = 0, s_axi_rready = 0, branch_retire = 0, exception_taken = 0;
   logic        extended_64bit_mode = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic        s_axi_rvalid, task_priority_report_en, l1_share_en, execute_disable_protection_en;
   logic        ext_id_xd_flag, general_protection_fault;
   logic [13:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [63:0] branch_addr = 0, page_table_base_lp0 = 0, page_table_base_lp1 = 1, a;
   logic [33:0] exp_q[$];
   int          fail_count = 0, n_tests = 0;
   pmc_regs u_pmc_regs (.*);
   initial forever #12.5 aclk = ~aclk;
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [33:0] seen, input logic [33:0] want);
      n_tests++;
      if (seen !== want) begin
         fail_count++;
         $display("unexpected at %0t: saw %h, expected %h", $time, seen, want);
      end
   endtask
   task automatic test_done();
      if (fail_count == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // ready/valid sampled at the falling edge, i.e. the value the next rising edge sees
   task automatic wr(input logic [13:0] ad, input logic [31:0] wd, input logic [3:0] st);
      logic aw_hit, w_hit, b_hit;
      @(posedge aclk);
      s_axi_awaddr <= ad;
      s_axi_wdata <= wd;
      s_axi_wstrb <= st;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(negedge aclk);
         {aw_hit, w_hit, b_hit} = {s_axi_awready, s_axi_wready, s_axi_bvalid};
         if (b_hit) check(s_axi_bresp, 2'b00);
         if (b_hit) check(general_protection_fault, 1'b0);
         @(posedge aclk);
         if (aw_hit) s_axi_awvalid <= 1'b0;
         if (w_hit) s_axi_wvalid <= 1'b0;
      end while (!b_hit);
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [13:0] ad, input logic [33:0] want);
      logic ar_hit, r_hit;
      @(posedge aclk);
      exp_q.push_back(want);
      s_axi_araddr <= ad;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(negedge aclk);
         {ar_hit, r_hit} = {s_axi_arready, s_axi_rvalid};
         @(posedge aclk);
         if (ar_hit) s_axi_arvalid <= 1'b0;
      end while (!r_hit);
      s_axi_rready <= 1'b0;
   endtask
   always @(negedge aclk) begin
      if (s_axi_rvalid && s_axi_rready) check({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(92));
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      rd(14'h0680, 34'h0);
      rd(14'h2680, 34'h0);
      check(task_priority_report_en, 1'b1);
      check(execute_disable_protection_en, 1'b1);
      for (int i = 0; i < 4; i++) begin
         d = $urandom;
         d[24:23] = i[1:0];
         wr(14'h0680, d, 4'hF);
         rd(14'h0680, {2'b00, d & 32'h0180_0000});
         check(task_priority_report_en, !d[23]);
         check(l1_share_en, d[24]);
         d = $urandom;
         d[2] = i[0];
         wr(14'h2680, d, 4'hF);
         rd(14'h2680, {2'b00, d & 32'h0000_0004});
         check(execute_disable_protection_en, !d[2]);
         check(ext_id_xd_flag, !d[2]);
      end
      // only lane 2 enabled: bit 24 must keep its last value
      wr(14'h0680, 32'h0180_0000, 4'h4);
      rd(14'h0680, {2'b00, 32'h0180_0000});
      wr(14'h0680, 32'h0, 4'hF);
      page_table_base_lp1 <= 64'h0;
      rd(14'h0684, 34'h0);
      check(l1_share_en, 1'b1);
      wr(14'h0684, 32'hFFFF_FFFF, 4'hF);
      rd(14'h0684, 34'h0);
      rd(14'h2684, 34'h0);
      rd(14'h0010, {2'b10, 32'h0});
      for (int m = 0; m < 2; m++) begin
         a = {$urandom, $urandom};
         extended_64bit_mode <= m[0];
         branch_addr <= a;
         branch_retire <= 1'b1;
         @(posedge aclk);
         branch_retire <= 1'b0;
         branch_addr <= ~a;
         exception_taken <= 1'b1;
         @(posedge aclk);
         exception_taken <= 1'b0;
         rd(14'h075C, {2'b00, a[31:0]});
         rd(14'h275C, {2'b00, m ? a[63:32] : 32'h0});
      end
      test_done();
   end
   initial begin
      #(25 * 4000);
      fail_count++;
      test_done();
   end
endmodule // tb_pmc_regs
bind pmc_regs pmc_regs_asserts #(.HAS_XD(HAS_XD), .HAS_SMT(HAS_SMT)) u_pmc_regs_asserts (.aclk, .aresetn,
   .s_axi_wvalid, .s_axi_bvalid, .s_axi_bready, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
   .task_priority_report_en, .l1_share_en, .execute_disable_protection_en, .ext_id_xd_flag,
   .general_protection_fault, .page_table_base_lp0, .page_table_base_lp1);
